// file: design/lube_spindle_supervisor.sv
// Top of the spindle lube supervisor: timing, fault latches and register port.
// Functional notes
// (R1) Oil fifteen seconds every twenty running minutes.
// (R2) Oil at power-on, stop at fifteen seconds.
// (R3) Boot bearing air with supply air, two minutes.
// (R4) Air while running, two minutes after stop.
// (R5) Mask oil pressure and bearing faults thirteen seconds.
// (R6) Heartbeat LED toggles during normal operation.
// (R7) Low air lights LED, requests emergency stop.
// (R8) Low oil level lights LED, requests hold.
// (R9) Low oil pressure lights LED, requests stop.
// (R10) Low bearing pressure lights own LED, stop.
// (R11) Reset button clears faults, even while running.
// (R12) Power cycle restarts the whole sequence.
// (R13) Button release gives two minutes of air.
// (R14) Faults and requests latch until a reset.
// (R15) Prescaled intervals, synchronised switch inputs.
`default_nettype none
`include "lube_map.svh"
module lube_spindle_supervisor #(
  parameter int unsigned TICK_CYCLES = `LUBE_SEC_NS / `LUBE_CLK_PERIOD_NS
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire logic [`LUBE_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [`LUBE_DATA_W-1:0]  reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output var  logic [`LUBE_DATA_W-1:0]  reg_rdata_o,
  input  wire logic                     air_ok_i,
  input  wire logic                     oil_level_ok_i,
  input  wire logic                     oil_press_ok_i,
  input  wire logic                     upper_bearing_ok_i,
  input  wire logic                     lower_bearing_ok_i,
  input  wire logic                     spindle_run_i,
  input  wire logic                     reset_btn_i,
  output var  logic                     oil_solenoid_o,
  output var  logic                     oil_led_o,
  output var  logic                     bearing_air_o,
  output var  logic                     air_led_o,
  output var  logic                     heartbeat_led_o,
  output var  logic                     low_air_led_o,
  output var  logic                     low_level_led_o,
  output var  logic                     oil_press_led_o,
  output var  logic                     upper_bearing_led_o,
  output var  logic                     lower_bearing_led_o,
  output var  logic                     estop_req_o,
  output var  logic                     feed_hold_o
);

  function automatic logic hits(input lube_pkg::lube_addr_t addr, input lube_pkg::lube_addr_t off);
    hits = (addr == off);
  endfunction

  lube_tick_if tick_if ();

  lube_pkg::lube_sw_t    raw_sw;
  lube_pkg::lube_sw_t    sw_s;
  lube_pkg::lube_fault_t fault_ff;
  lube_pkg::lube_fault_t nxt_fault;
  lube_pkg::lube_fault_t fault_set;
  logic [`LUBE_UP_W-1:0]  up_s_ff;
  logic [`LUBE_UP_W-1:0]  air_left_ff;
  logic [`LUBE_UP_W-1:0]  nxt_air_left;
  logic [`LUBE_CYC_W-1:0] cyc_s_ff;
  logic                   btn_d_ff;
  logic                   btn_press;
  logic                   btn_release;
  logic                   sw_clear;
  logic                   sw_prime;
  logic                   clr;
  logic                   armed;
  logic                   boot_oil;
  logic                   boot_air;
  logic                   nxt_oil;
  logic                   nxt_air;

  // Pins are gathered into one vector so that one synchroniser serves all.
  always_comb begin
    raw_sw                   = '0;
    raw_sw[`LUBE_SW_AIR]     = air_ok_i;
    raw_sw[`LUBE_SW_LEVEL]   = oil_level_ok_i;
    raw_sw[`LUBE_SW_OILP]    = oil_press_ok_i;
    raw_sw[`LUBE_SW_UPPER]   = upper_bearing_ok_i;
    raw_sw[`LUBE_SW_LOWER]   = lower_bearing_ok_i;
    raw_sw[`LUBE_SW_SPINDLE] = spindle_run_i;
    raw_sw[`LUBE_SW_BUTTON]  = reset_btn_i;
  end

  lube_sync u_sync ( // [R15]
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   (raw_sw),
    .sync_o    (sw_s)
  );

  lube_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .tick_if   (tick_if)
  );

  // Button edges and software strobes.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      btn_d_ff <= 1'b0;
    end else begin
      btn_d_ff <= sw_s[`LUBE_SW_BUTTON];
    end
  end

  assign btn_press   = sw_s[`LUBE_SW_BUTTON] && !btn_d_ff;
  assign btn_release = !sw_s[`LUBE_SW_BUTTON] && btn_d_ff;
  assign sw_clear    = reg_wr_i && hits(reg_addr_i, `LUBE_REG_CTRL) && reg_wdata_i[`LUBE_CTRL_CLEAR];
  assign sw_prime    = reg_wr_i && hits(reg_addr_i, `LUBE_REG_CTRL) && reg_wdata_i[`LUBE_CTRL_PRIME];
  // The spindle state does not gate the clear, so it works while running.
  assign clr         = btn_press || sw_clear; // [R11]

  // Seconds since power-on, saturating at 127, just past the longest boot window of 120.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      up_s_ff <= `LUBE_UP_ZERO; // [R12]
    end else if (tick_if.sec_tick && up_s_ff != `LUBE_UP_MAX) begin
      up_s_ff <= up_s_ff + 1'b1; // [R15]
    end
  end

  assign armed    = (up_s_ff >= `LUBE_ARM_DELAY_S); // [R5]
  assign boot_oil = (up_s_ff < `LUBE_BOOT_OIL_S); // [R2]
  assign boot_air = (up_s_ff < `LUBE_AIR_HOLD_S) && sw_s[`LUBE_SW_AIR]; // [R3]

  // Running-time phase of the oiling cycle; each start begins with a pulse.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !sw_s[`LUBE_SW_SPINDLE]) begin
      cyc_s_ff <= `LUBE_CYC_ZERO;
    end else if (tick_if.sec_tick) begin
      if (cyc_s_ff == `LUBE_OIL_PERIOD_S - 1'b1) begin
        cyc_s_ff <= `LUBE_CYC_ZERO; // [R1]
      end else begin
        cyc_s_ff <= cyc_s_ff + 1'b1;
      end
    end
  end

  // Air hold-off timer, reloaded while running and by a priming request.
  always_comb begin
    nxt_air_left = air_left_ff;
    if (sw_s[`LUBE_SW_SPINDLE] || btn_release || sw_prime) begin
      nxt_air_left = `LUBE_AIR_HOLD_S; // [R4] [R13]
    end else if (tick_if.sec_tick && air_left_ff != `LUBE_AIR_ZERO) begin
      nxt_air_left = air_left_ff - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      air_left_ff <= `LUBE_AIR_ZERO;
    end else begin
      air_left_ff <= nxt_air_left;
    end
  end

  assign nxt_oil = boot_oil || (sw_s[`LUBE_SW_SPINDLE] && cyc_s_ff < `LUBE_OIL_PULSE_S); // [R1] [R2]
  assign nxt_air = boot_air || sw_s[`LUBE_SW_SPINDLE] || air_left_ff != `LUBE_AIR_ZERO; // [R3] [R4] [R13]

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      oil_solenoid_o <= 1'b0;
      oil_led_o      <= 1'b0;
      bearing_air_o  <= 1'b0;
      air_led_o      <= 1'b0;
    end else begin
      oil_solenoid_o <= nxt_oil;
      oil_led_o      <= nxt_oil;
      bearing_air_o  <= nxt_air;
      air_led_o      <= nxt_air;
    end
  end

  // A heartbeat that stops toggling means the prescaler or clock has died.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      heartbeat_led_o <= 1'b0;
    end else if (tick_if.half_tick) begin
      heartbeat_led_o <= !heartbeat_led_o; // [R6]
    end
  end

  // A bad switch sets its fault; a set in the clear cycle survives the clear.
  assign fault_set = ~sw_s[`LUBE_FAULT_W-1:0] // [R7] [R8] [R9] [R10]
                   & (armed ? `LUBE_FAULT_ALL : ~`LUBE_ARM_MASK); // [R5]
  assign nxt_fault = fault_set | (clr ? `LUBE_FAULT_NONE : fault_ff); // [R14] [R11]

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      fault_ff <= `LUBE_FAULT_NONE; // [R12]
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  // Indicators and requests are flops of their own, loaded in step with the latches.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      low_air_led_o       <= 1'b0;
      low_level_led_o     <= 1'b0;
      oil_press_led_o     <= 1'b0;
      upper_bearing_led_o <= 1'b0;
      lower_bearing_led_o <= 1'b0;
      estop_req_o         <= 1'b0;
      feed_hold_o         <= 1'b0;
    end else begin
      low_air_led_o       <= nxt_fault[`LUBE_SW_AIR]; // [R7]
      low_level_led_o     <= nxt_fault[`LUBE_SW_LEVEL]; // [R8]
      oil_press_led_o     <= nxt_fault[`LUBE_SW_OILP]; // [R9]
      upper_bearing_led_o <= nxt_fault[`LUBE_SW_UPPER]; // [R10]
      lower_bearing_led_o <= nxt_fault[`LUBE_SW_LOWER]; // [R10]
      estop_req_o         <= |(nxt_fault & `LUBE_ESTOP_MASK); // [R7] [R9] [R10]
      feed_hold_o         <= |(nxt_fault & `LUBE_HOLD_MASK); // [R8]
    end
  end

  // Register read port; unmapped offsets and the control register read zero.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= '0;
      if (hits(reg_addr_i, `LUBE_REG_STATUS)) begin
        reg_rdata_o[`LUBE_FAULT_W-1:0] <= fault_ff;
        reg_rdata_o[`LUBE_STAT_OIL]    <= oil_solenoid_o;
        reg_rdata_o[`LUBE_STAT_AIR]    <= bearing_air_o;
        reg_rdata_o[`LUBE_STAT_ARMED]  <= armed;
      end else if (hits(reg_addr_i, `LUBE_REG_UPTIME)) begin
        reg_rdata_o[`LUBE_UP_W-1:0] <= up_s_ff;
      end else if (hits(reg_addr_i, `LUBE_REG_INPUTS)) begin
        reg_rdata_o[`LUBE_SW_W-1:0] <= sw_s;
      end
    end else begin
      reg_rdata_o <= '0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_oil_cycle_on: assert property ( // [R1]
    (sw_s[`LUBE_SW_SPINDLE] && cyc_s_ff < `LUBE_OIL_PULSE_S) |=> (oil_solenoid_o && oil_led_o))
    else $error("oiling pulse missing while running");
  a_oil_cycle_off: assert property ( // [R1]
    (sw_s[`LUBE_SW_SPINDLE] && !boot_oil && cyc_s_ff >= `LUBE_OIL_PULSE_S) |=> !oil_solenoid_o)
    else $error("oil solenoid on outside its pulse");
  // Operands are sampled, so the release edge still sees reset high and skips the
  // attempt whose next cycle would judge outputs loaded while reset was held.
  a_boot_oil: assert property ( // [R2]
    (!rst_i && up_s_ff < `LUBE_BOOT_OIL_S) |=> oil_solenoid_o)
    else $error("power-on oiling pulse missing");
  a_boot_air: assert property ( // [R3]
    (!rst_i && up_s_ff < `LUBE_AIR_HOLD_S && sw_s[`LUBE_SW_AIR]) |=> (bearing_air_o && air_led_o))
    else $error("power-on bearing air missing");
  a_run_air: assert property ( // [R4]
    $fell(sw_s[`LUBE_SW_SPINDLE]) |-> (air_left_ff == `LUBE_AIR_HOLD_S) ##1 bearing_air_o)
    else $error("bearing air hold-off not started at spindle stop");
  a_fault_mask: assert property ( // [R5]
    (up_s_ff < `LUBE_ARM_DELAY_S) |-> !(oil_press_led_o || upper_bearing_led_o || lower_bearing_led_o))
    else $error("masked fault shown during start-up");
  a_hb_toggle: assert property (tick_if.half_tick |=> (heartbeat_led_o != $past(heartbeat_led_o))) // [R6]
    else $error("heartbeat did not toggle");
  a_air_estop: assert property (!sw_s[`LUBE_SW_AIR] |=> (low_air_led_o && estop_req_o)) // [R7]
    else $error("low air not reported");
  a_level_hold: assert property (!sw_s[`LUBE_SW_LEVEL] |=> (low_level_led_o && feed_hold_o)) // [R8]
    else $error("low oil level not reported as hold");
  a_oilp_estop: assert property ((!sw_s[`LUBE_SW_OILP] && armed) |=> (oil_press_led_o && estop_req_o)) // [R9]
    else $error("low oil pressure not reported");
  // Each bearing has its own indicator, so each is checked on its own.
  a_bearing_estop: assert property ( // [R10]
    (!sw_s[`LUBE_SW_LOWER] && armed) |=> (lower_bearing_led_o && estop_req_o))
    else $error("low bearing pressure not reported");
  a_upper_estop: assert property ( // [R10]
    (!sw_s[`LUBE_SW_UPPER] && armed) |=> (upper_bearing_led_o && estop_req_o))
    else $error("low upper bearing pressure not reported");
  a_fault_clear: assert property ( // [R11]
    (btn_press && &sw_s[`LUBE_FAULT_W-1:0]) |=> (!estop_req_o && !feed_hold_o && !low_air_led_o))
    else $error("reset button did not clear faults");
  a_power_cycle: assert property (@(posedge sys_clk_i) disable iff (1'b0) // [R12]
    rst_i |=> (up_s_ff == `LUBE_UP_ZERO && !estop_req_o && !feed_hold_o))
    else $error("reset did not restore power-on state");
  a_prime_air: assert property (btn_release |=> ##1 bearing_air_o) // [R13]
    else $error("button release gave no priming air");
  a_fault_latch: assert property ((estop_req_o && !clr) |=> estop_req_o) // [R14]
    else $error("stop request dropped without reset");

  c_estop:      cover property (!estop_req_o ##1 estop_req_o);
  c_run_oil:    cover property (sw_s[`LUBE_SW_SPINDLE] && !boot_oil && oil_solenoid_o);
  c_prime:      cover property (btn_release ##2 bearing_air_o);
  c_armed:      cover property ($rose(armed));
  c_clear:      cover property (clr && |fault_ff);
endmodule
`default_nettype wire

// file: design/lube_map.svh
// Named offsets, field positions, reset values and timing figures of the spindle lube supervisor.
`ifndef LUBE_MAP_SVH
`define LUBE_MAP_SVH

// Register port widths.
`define LUBE_ADDR_W        4
`define LUBE_DATA_W        8

// Register offsets on the plain register port.
`define LUBE_REG_STATUS    4'h0
`define LUBE_REG_CTRL      4'h1
`define LUBE_REG_UPTIME    4'h2
`define LUBE_REG_INPUTS    4'h3

// Control register fields (write one to act, the register reads as zero).
`define LUBE_CTRL_CLEAR    0
`define LUBE_CTRL_PRIME    1

// Status register fields above the fault bits.
`define LUBE_STAT_OIL      5
`define LUBE_STAT_AIR      6
`define LUBE_STAT_ARMED    7

// Switch vector positions; the first five double as fault positions.
`define LUBE_SW_W          7
`define LUBE_SW_AIR        0
`define LUBE_SW_LEVEL      1
`define LUBE_SW_OILP       2
`define LUBE_SW_UPPER      3
`define LUBE_SW_LOWER      4
`define LUBE_SW_SPINDLE    5
`define LUBE_SW_BUTTON     6
// Synchroniser reset value: switches good, spindle stopped, button released.
`define LUBE_SW_IDLE       7'h1F

// Fault groups.
`define LUBE_FAULT_W       5
`define LUBE_FAULT_NONE    5'h00
`define LUBE_FAULT_ALL     5'h1F
`define LUBE_ARM_MASK      5'h1C
`define LUBE_ESTOP_MASK    5'h1D
`define LUBE_HOLD_MASK     5'h02

// Clock and prescaler.
`define LUBE_CLK_PERIOD_NS 40
`define LUBE_SEC_NS        1000000000
`define LUBE_PRESC_W       25
`define LUBE_PRESC_ZERO    25'h0000000

// Intervals in seconds, each at the width of the counter it meets.
`define LUBE_UP_W          7
`define LUBE_UP_ZERO       7'h00
`define LUBE_UP_MAX        7'h7F
`define LUBE_BOOT_OIL_S    7'h0F
`define LUBE_ARM_DELAY_S   7'h0D
`define LUBE_AIR_HOLD_S    7'h78
`define LUBE_AIR_ZERO      7'h00
`define LUBE_CYC_W         11
`define LUBE_CYC_ZERO      11'h000
`define LUBE_OIL_PULSE_S   11'h00F
`define LUBE_OIL_PERIOD_S  11'h4B0

`endif

// file: design/lube_pkg.sv
// Shared types of the spindle lube supervisor.
`default_nettype none
`include "lube_map.svh"
package lube_pkg;
  typedef logic [`LUBE_FAULT_W-1:0] lube_fault_t;
  typedef logic [`LUBE_SW_W-1:0]    lube_sw_t;
  typedef logic [`LUBE_DATA_W-1:0]  lube_data_t;
  typedef logic [`LUBE_ADDR_W-1:0]  lube_addr_t;
endpackage
`default_nettype wire

// file: design/lube_tick_if.sv
// Carrier of the one-second and half-second enable pulses.
`default_nettype none
interface lube_tick_if;
  logic sec_tick;
  logic half_tick;
  modport src (output sec_tick, output half_tick);
  modport dst (input sec_tick, input half_tick);
endinterface
`default_nettype wire

// file: design/lube_sync.sv
// Two-stage synchroniser for the switch and button pins.
`default_nettype none
`include "lube_map.svh"
module lube_sync (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [`LUBE_SW_W-1:0] async_i,
  output var  logic [`LUBE_SW_W-1:0] sync_o
);
  localparam logic [`LUBE_SW_W-1:0] IDLE = `LUBE_SW_IDLE;

  logic [`LUBE_SW_W-1:0] stage1_ff;

  genvar g;
  generate
    for (g = 0; g < `LUBE_SW_W; g++) begin : g_bit
      // The first stage feeds only the second one.
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          // Reset to the idle pin levels, so that release raises no false fault or edge.
          stage1_ff[g] <= IDLE[g];
          sync_o[g]    <= IDLE[g];
        end else begin
          stage1_ff[g] <= async_i[g];
          sync_o[g]    <= stage1_ff[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: design/lube_tick_gen.sv
// Prescaler that turns the system clock into second and half-second enables.
`default_nettype none
`include "lube_map.svh"
module lube_tick_gen #(
  parameter int unsigned TICK_CYCLES = `LUBE_SEC_NS / `LUBE_CLK_PERIOD_NS
) (
  input  wire logic     sys_clk_i,
  input  wire logic     rst_i,
  lube_tick_if.src      tick_if
);
  localparam logic [`LUBE_PRESC_W-1:0] LAST = `LUBE_PRESC_W'(TICK_CYCLES - 1);
  localparam logic [`LUBE_PRESC_W-1:0] HALF = `LUBE_PRESC_W'(TICK_CYCLES / 2 - 1);

  logic [`LUBE_PRESC_W-1:0] cnt_ff;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || cnt_ff == LAST) begin
      cnt_ff <= `LUBE_PRESC_ZERO;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Ticks are registered so that every second starts cleanly after reset.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tick_if.sec_tick  <= 1'b0;
      tick_if.half_tick <= 1'b0;
    end else begin
      tick_if.sec_tick  <= (cnt_ff == LAST); // [R15]
      tick_if.half_tick <= (cnt_ff == LAST) || (cnt_ff == HALF);
    end
  end

  a_tick_spacing: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tick_if.sec_tick |=> !tick_if.sec_tick) // [R15]
    else $error("second tick lasted more than one cycle");
endmodule
`default_nettype wire

// file: test/lube_plant_model.sv
// Behavioural model of the pressure switches and the machine control around the supervisor.
`default_nettype none
module lube_plant_model (
  input  wire logic       sys_clk_i,
  input  wire logic [4:0] fault_cmd_i,
  input  wire logic [2:0] lag_i,
  input  wire logic       run_cmd_i,
  input  wire logic       estop_req_i,
  output wire logic       air_ok_o,
  output wire logic       oil_level_ok_o,
  output wire logic       oil_press_ok_o,
  output wire logic       upper_bearing_ok_o,
  output wire logic       lower_bearing_ok_o,
  output wire logic       spindle_run_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] hist_ff [8];
  logic       stopped_ff;
  logic [4:0] bad;
  // A delay line lets a switch react slowly without swallowing short dips.
  initial begin
    for (int i = 0; i < 8; i++) begin
      hist_ff[i] = 5'h00;
    end
    stopped_ff = 1'b0;
  end
  always @(posedge sys_clk_i) begin
    hist_ff[0] <= fault_cmd_i;
    for (int i = 1; i < 8; i++) begin
      hist_ff[i] <= hist_ff[i-1];
    end
    // The control drops the spindle on an emergency stop until the run command is withdrawn.
    if (!run_cmd_i) begin
      stopped_ff <= 1'b0;
    end else if (estop_req_i) begin
      stopped_ff <= 1'b1;
    end
  end
  assign bad                = hist_ff[lag_i];
  assign air_ok_o           = ~bad[0];
  assign oil_level_ok_o     = ~bad[1];
  assign oil_press_ok_o     = ~bad[2];
  assign upper_bearing_ok_o = ~bad[3];
  assign lower_bearing_ok_o = ~bad[4];
  assign spindle_run_o      = run_cmd_i & ~stopped_ff & ~estop_req_i;
endmodule
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench of the spindle lube supervisor.
`default_nettype none
`include "lube_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 20;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  lube_pkg::lube_addr_t reg_addr = 4'h0;
  lube_pkg::lube_data_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  lube_pkg::lube_data_t reg_rdata;
  lube_pkg::lube_data_t rd_v;
  logic [4:0] fault_cmd = 5'h00;
  logic [2:0] lag = 3'h0;
  logic run_cmd = 1'b0;
  logic reset_btn = 1'b0;
  logic air_ok, lev_ok, oilp_ok, up_ok, lo_ok, spin;
  logic oil, oil_led, air, air_led, hb, estop, hold;
  logic [4:0] leds;
  int up_cyc = 0;
  int num_errors = 0;
  int compares = 0;
  int m;
  int n;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) up_cyc <= rst ? 0 : up_cyc + 1;
  lube_plant_model u_plant (.sys_clk_i(sys_clk), .fault_cmd_i(fault_cmd), .lag_i(lag), .run_cmd_i(run_cmd),
    .estop_req_i(estop), .air_ok_o(air_ok), .oil_level_ok_o(lev_ok), .oil_press_ok_o(oilp_ok),
    .upper_bearing_ok_o(up_ok), .lower_bearing_ok_o(lo_ok), .spindle_run_o(spin));
  lube_spindle_supervisor #(.TICK_CYCLES(S)) u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .air_ok_i(air_ok),
    .oil_level_ok_i(lev_ok), .oil_press_ok_i(oilp_ok), .upper_bearing_ok_i(up_ok), .lower_bearing_ok_i(lo_ok),
    .spindle_run_i(spin), .reset_btn_i(reset_btn), .oil_solenoid_o(oil), .oil_led_o(oil_led),
    .bearing_air_o(air), .air_led_o(air_led), .heartbeat_led_o(hb), .low_air_led_o(leds[0]),
    .low_level_led_o(leds[1]), .oil_press_led_o(leds[2]), .upper_bearing_led_o(leds[3]),
    .lower_bearing_led_o(leds[4]), .estop_req_o(estop), .feed_hold_o(hold));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_status(input logic [4:0] f, input logic o, input logic a, input logic arm);
    return {arm, a, o, f};
  endfunction
  function automatic logic [7:0] exp_req(input int idx);
    logic [4:0] e;
    logic [4:0] h;
    e = `LUBE_ESTOP_MASK;
    h = `LUBE_HOLD_MASK;
    return {6'h00, e[idx], h[idx]};
  endfunction
  task automatic at(input int c);
    while (up_cyc < c) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Oil and air outputs each drive an LED that must follow them exactly.
  task automatic outs(input logic o, input logic a);
    check("oil", {6'h00, oil, oil_led}, {6'h00, o, o});
    check("air", {6'h00, air, air_led}, {6'h00, a, a});
  endtask
  task automatic rd(input lube_pkg::lube_addr_t a, output lube_pkg::lube_data_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic wr(input lube_pkg::lube_addr_t a, input lube_pkg::lube_data_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic inject(input int idx, input int len);
    @(posedge sys_clk);
    fault_cmd[idx] <= 1'b1;
    cyc(len);
    fault_cmd[idx] <= 1'b0;
    cyc(len + 14);
    #1;
  endtask
  task automatic button(input int len);
    @(posedge sys_clk);
    reset_btn <= 1'b1;
    cyc(len);
    reset_btn <= 1'b0;
    cyc(6);
    #1;
  endtask
  task automatic final_report();
    $display("Checks made: %0d, mismatches: %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end

  initial begin
    void'($urandom(86480));
    cyc(12);
    rst <= 1'b0;
    at(10);
    outs(1'b1, 1'b1);
    n = 0;
    for (int i = 0; i < 45; i++) begin
      rd_v[0] = hb;
      cyc(1);
      #1;
      n += (hb !== rd_v[0]);
    end
    check("heartbeat", 8'(n >= 4), 8'h01);
    at(60);
    inject(2, 40);
    inject(3, 30);
    at(250);
    check("masked", {3'h0, leds}, 8'h00);
    at(280);
    outs(1'b1, 1'b1);
    lag <= 3'($urandom_range(0, 5));
    inject(2, $urandom_range(1, 8));
    at(330);
    outs(1'b0, 1'b1);
    check("oilp latch", {3'h0, leds}, 8'h04);
    check("oilp req", {6'h00, estop, hold}, exp_req(2));
    rd(`LUBE_REG_STATUS, rd_v);
    check("status", rd_v, exp_status(5'h04, 1'b0, 1'b1, 1'b1));
    at(410);
    rd(`LUBE_REG_UPTIME, rd_v);
    check("uptime", rd_v, 8'h14);
    wr(`LUBE_REG_STATUS, 8'hFF);
    rd(`LUBE_REG_STATUS, rd_v);
    check("ro status", rd_v, exp_status(5'h04, 1'b0, 1'b1, 1'b1));
    wr(`LUBE_REG_CTRL, 8'h01);
    rd(`LUBE_REG_STATUS, rd_v);
    check("cleared", rd_v, exp_status(5'h00, 1'b0, 1'b1, 1'b1));
    rd(`LUBE_REG_CTRL, rd_v);
    check("ctrl", rd_v, 8'h00);
    rd(4'hF, rd_v);
    check("unmapped", rd_v, 8'h00);
    rd(`LUBE_REG_INPUTS, rd_v);
    check("inputs", rd_v, 8'h1F);
    at(119 * S);
    outs(1'b0, 1'b1);
    at(122 * S);
    outs(1'b0, 1'b0);
    for (int idx = 0; idx < 5; idx++) begin
      lag <= 3'($urandom_range(0, 5));
      inject(idx, $urandom_range(1, 8));
      check("fault led", {3'h0, leds}, {3'h0, 5'h01 << idx});
      check("fault req", {6'h00, estop, hold}, exp_req(idx));
      button($urandom_range(1, 6));
      check("btn clear", {1'b0, estop, hold, leds}, 8'h00);
    end
    m = up_cyc;
    at(m + 118 * S);
    outs(1'b0, 1'b1);
    at(m + 122 * S);
    outs(1'b0, 1'b0);
    wr(`LUBE_REG_CTRL, 8'h02);
    cyc(3);
    #1;
    outs(1'b0, 1'b1);
    @(posedge sys_clk);
    run_cmd <= 1'b1;
    m = up_cyc;
    cyc(8);
    #1;
    outs(1'b1, 1'b1);
    inject(1, $urandom_range(1, 8));
    check("hold run", {5'h00, spin, estop, hold}, 8'h05);
    button(3);
    check("clear run", {5'h00, spin, estop, hold}, 8'h04);
    at(m + 14 * S);
    outs(1'b1, 1'b1);
    at(m + 17 * S);
    outs(1'b0, 1'b1);
    at(m + 23970);
    outs(1'b0, 1'b1);
    at(m + 24030);
    outs(1'b1, 1'b1);
    @(posedge sys_clk);
    run_cmd <= 1'b0;
    m = up_cyc;
    at(m + 119 * S);
    outs(1'b0, 1'b1);
    at(m + 122 * S);
    outs(1'b0, 1'b0);
    inject(0, 4);
    check("pre power", {3'h0, leds}, 8'h01);
    @(posedge sys_clk);
    rst <= 1'b1;
    cyc(12);
    rst <= 1'b0;
    at(10);
    check("power cycle", {1'b0, estop, hold, leds}, 8'h00);
    outs(1'b1, 1'b1);
    final_report();
  end
endmodule
`default_nettype wire
